/* rtl/isc_top.sv */
// interrupt pin, strap capture, clock output select and serial-out enable
// assumes pins are asynchronous and the host port is on ref_clk
`include "isc_defs.svh"
module isc_top #(
    parameter int W          = 8,
    parameter int FORCE_CYC  = `ISC_FORCE_CYCLES
) (
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic [3:0]   reg_addr,
    input  wire logic [W-1:0] reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic [W-1:0]      reg_rdata,
    input  wire logic [W-1:0] line_events,
    input  wire logic [W-1:0] st_events,
    input  wire logic [W-1:0] misc_events,
    input  wire logic         mode_irq_pin_in,
    output logic              irq_n_out,
    output logic              irq_n_oe,
    input  wire logic         host_serial_in,
    input  wire logic         auto_activation_pin,
    input  wire logic         host_read_active,
    input  wire logic         host_serial_out_d,
    output logic              host_serial_out,
    output logic              host_serial_out_oe,
    input  wire logic         line_active,
    input  wire logic         clk_15m36,
    input  wire logic         clk_10m24_line,
    input  wire logic         clk_10m24_free,
    output logic              clock_out,
    output logic              clock_out_oe,
    output logic              activation_bit_select,
    output logic              sync_8khz_function,
    output logic              auto_activation_ctl,
    output logic              activation_start
);
    logic [1:0]   rst_sync;
    logic         rst_n;
    logic [1:0]   rel_cnt;
    logic [1:0]   s_mode;
    logic [1:0]   s_sync;
    logic [1:0]   s_auto;
    logic [1:0]   s_rd;
    logic [1:0]   s_sdo;
    logic [1:0]   s_act;
    logic [1:0]   s_c15;
    logic [1:0]   s_c10l;
    logic [1:0]   s_c10f;
    logic [W-1:0] line_irq_reg;
    logic [W-1:0] st_irq_reg;
    logic [W-1:0] misc_irq_reg;
    logic [W-1:0] line_mask;
    logic [W-1:0] st_mask;
    logic [W-1:0] misc_mask;
    logic [31:0]  force_cnt;
    logic [2:0]   pend;
    isc_pkg::isc_gcr0_t global_control_reg_zero;
    logic         irq_rd;
    logic         next_clk;

    // summary bit of one interrupt register: any bit set and not masked
    function automatic logic pending(input logic [W-1:0] flags,
                                     input logic [W-1:0] mask);
        return |(flags & ~mask);
    endfunction

    // host read strobe aimed at one particular interrupt register
    function automatic logic irq_hit(input logic       rd,
                                     input logic [3:0] addr,
                                     input logic [3:0] which);
        return rd && (addr == which);
    endfunction

    // the two rate codes that drive the clock pin; the others leave it floating
    function automatic logic clk_on(input logic [1:0] sel);
        return (sel == `ISC_CKSEL_15M36) || (sel == `ISC_CKSEL_10M24);
    endfunction

    // readback word of the clock select and auto-activation control register
    function automatic logic [W-1:0] gcr0_word(input isc_pkg::isc_gcr0_t g);
        logic [W-1:0] w;
        w                          = '0;
        w[`ISC_GCR0_CKSEL_LO +: 2] = g.sel;
        w[`ISC_GCR0_AUTO_ACTIVATION_CTL]       = g.auto_act;
        return w;
    endfunction

    // readback word of the strap status register
    function automatic logic [W-1:0] gcr2_word(input logic act_sel);
        logic [W-1:0] w;
        w                   = '0;
        w[`ISC_GCR2_ACTIVATION_BIT_SELECT] = act_sel;
        return w;
    endfunction

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) rst_sync <= 2'h0;
        else rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // strap pin synchronisers, reset to each pin's idle level
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_mode <= `ISC_PIN_HIGH;
            s_sync <= `ISC_PIN_LOW;
            s_auto <= `ISC_PIN_LOW;
        end else begin
            s_mode <= {s_mode[0], mode_irq_pin_in};
            s_sync <= {s_sync[0], host_serial_in};
            s_auto <= {s_auto[0], auto_activation_pin};
        end
    end

    // host serial pin synchronisers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_rd  <= `ISC_PIN_LOW;
            s_sdo <= `ISC_PIN_LOW;
        end else begin
            s_rd  <= {s_rd[0], host_read_active};
            s_sdo <= {s_sdo[0], host_serial_out_d};
        end
    end

    // line state and clock pin synchronisers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_act  <= `ISC_PIN_LOW;
            s_c15  <= `ISC_PIN_LOW;
            s_c10l <= `ISC_PIN_LOW;
            s_c10f <= `ISC_PIN_LOW;
        end else begin
            s_act  <= {s_act[0], line_active};
            s_c15  <= {s_c15[0], clk_15m36};
            s_c10l <= {s_c10l[0], clk_10m24_line};
            s_c10f <= {s_c10f[0], clk_10m24_free};
        end
    end

    // strap capture once synchronised pins are valid after release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_cnt               <= 2'h0;
            activation_bit_select <= 1'b1;
            sync_8khz_function    <= 1'b0;
            activation_start      <= 1'b0;
        end else begin
            activation_start <= 1'b0;
            if (rel_cnt != `ISC_STRAP_DONE) rel_cnt <= rel_cnt + 2'h1;
            if (rel_cnt == `ISC_STRAP_TAKE) begin
                activation_bit_select <= s_mode[1];
                sync_8khz_function    <= !s_sync[1];
                activation_start      <= !s_auto[1];
            end
        end
    end

    // global control: clock select and auto-activation bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            global_control_reg_zero.sel      <= `ISC_CKSEL_OFF;
            global_control_reg_zero.auto_act <= 1'b1;
        end else if (rel_cnt == `ISC_STRAP_TAKE && !s_auto[1]) begin
            global_control_reg_zero.auto_act <= 1'b0;
        end else if (reg_wr && reg_addr == `ISC_ADDR_GCR0) begin
            global_control_reg_zero.sel      <= reg_wdata[`ISC_GCR0_CKSEL_LO +: 2];
            global_control_reg_zero.auto_act <= reg_wdata[`ISC_GCR0_AUTO_ACTIVATION_CTL];
        end
    end
    assign auto_activation_ctl = global_control_reg_zero.auto_act;

    // any host read of an interrupt register opens the forced-high interval
    assign irq_rd = irq_hit(reg_rd, reg_addr, `ISC_ADDR_LINE_IRQ) ||
                    irq_hit(reg_rd, reg_addr, `ISC_ADDR_ST_IRQ)   ||
                    irq_hit(reg_rd, reg_addr, `ISC_ADDR_MISC_IRQ);

    // line-side interrupt bits: a new event beats the read clear, mask ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_irq_reg <= '0;
        end else if (irq_hit(reg_rd, reg_addr, `ISC_ADDR_LINE_IRQ)) begin
            line_irq_reg <= line_events;
        end else begin
            line_irq_reg <= line_irq_reg | line_events;
        end
    end

    // s/t-side interrupt bits: a new event beats the read clear, mask ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_irq_reg <= '0;
        end else if (irq_hit(reg_rd, reg_addr, `ISC_ADDR_ST_IRQ)) begin
            st_irq_reg <= st_events;
        end else begin
            st_irq_reg <= st_irq_reg | st_events;
        end
    end

    // misc interrupt bits: a new event beats the read clear, mask ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_irq_reg <= '0;
        end else if (irq_hit(reg_rd, reg_addr, `ISC_ADDR_MISC_IRQ)) begin
            misc_irq_reg <= misc_events;
        end else begin
            misc_irq_reg <= misc_irq_reg | misc_events;
        end
    end

    // line-side mask, one bit masks, all masked out of reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_mask <= `ISC_MASK_RESET;
        end else if (reg_wr && reg_addr == `ISC_ADDR_LINE_MASK) begin
            line_mask <= reg_wdata;
        end
    end

    // s/t-side mask, one bit masks, all masked out of reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_mask <= `ISC_MASK_RESET;
        end else if (reg_wr && reg_addr == `ISC_ADDR_ST_MASK) begin
            st_mask <= reg_wdata;
        end
    end

    // misc mask, one bit masks, all masked out of reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_mask <= `ISC_MASK_RESET;
        end else if (reg_wr && reg_addr == `ISC_ADDR_MISC_MASK) begin
            misc_mask <= reg_wdata;
        end
    end

    // per-register pending summary
    assign pend = {pending(misc_irq_reg, misc_mask), pending(st_irq_reg, st_mask),
                   pending(line_irq_reg, line_mask)};

    // forced-high interval after an interrupt register read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            force_cnt <= '0;
        end else if (irq_rd) begin
            force_cnt <= 32'(FORCE_CYC);
        end else if (force_cnt != '0) begin
            force_cnt <= force_cnt - 32'h1;
        end
    end

    // open-drain interrupt pin, mode strap shares it while in reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_out <= 1'b1;
            irq_n_oe  <= 1'b0;
        end else begin
            irq_n_out <= 1'b0;
            irq_n_oe  <= (rel_cnt == `ISC_STRAP_DONE) && (force_cnt == '0) && !irq_rd
                         && (|pend);
        end
    end

    // register read port, data one cycle later
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) reg_rdata <= '0;
        else if (reg_rd) begin
            unique case (reg_addr)
                `ISC_ADDR_LINE_IRQ:  reg_rdata <= line_irq_reg;
                `ISC_ADDR_ST_IRQ:    reg_rdata <= st_irq_reg;
                `ISC_ADDR_MISC_IRQ:  reg_rdata <= misc_irq_reg;
                `ISC_ADDR_LINE_MASK: reg_rdata <= line_mask;
                `ISC_ADDR_ST_MASK:   reg_rdata <= st_mask;
                `ISC_ADDR_MISC_MASK: reg_rdata <= misc_mask;
                `ISC_ADDR_GLOBAL:    reg_rdata <= W'({pend});
                `ISC_ADDR_GCR0:      reg_rdata <= gcr0_word(global_control_reg_zero);
                `ISC_ADDR_GCR2:      reg_rdata <= gcr2_word(activation_bit_select);
                default:             reg_rdata <= '0;
            endcase
        end
    end

    // serial data output driven only during host reads
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_serial_out    <= 1'b0;
            host_serial_out_oe <= 1'b0;
        end else begin
            host_serial_out    <= s_sdo[1];
            host_serial_out_oe <= s_rd[1];
        end
    end

    // clock output select; 10.24 follows line timing when line active
    always_comb begin
        next_clk = 1'b0;
        unique case (global_control_reg_zero.sel)
            `ISC_CKSEL_15M36: next_clk = s_c15[1];
            `ISC_CKSEL_10M24: next_clk = s_act[1] ? s_c10l[1] : s_c10f[1];
            default:          next_clk = 1'b0;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_out    <= 1'b0;
            clock_out_oe <= 1'b0;
        end else begin
            clock_out    <= next_clk;
            clock_out_oe <= clk_on(global_control_reg_zero.sel);
        end
    end
endmodule

/* rtl/isc_defs.svh */
// constants for the interrupt, strap and clock-output block
// assumes a 50 MHz ref_clk and a plain register port with one-cycle strobes
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH
`define ISC_ADDR_LINE_IRQ   4'h0
`define ISC_ADDR_ST_IRQ     4'h1
`define ISC_ADDR_MISC_IRQ   4'h2
`define ISC_ADDR_LINE_MASK  4'h3
`define ISC_ADDR_ST_MASK    4'h4
`define ISC_ADDR_MISC_MASK  4'h5
`define ISC_ADDR_GLOBAL     4'h6
`define ISC_ADDR_GCR0       4'h7
`define ISC_ADDR_GCR2       4'h8
`define ISC_GCR0_AUTO_ACTIVATION_CTL    6
`define ISC_GCR0_CKSEL_LO   1
`define ISC_GCR2_ACTIVATION_BIT_SELECT     6
`define ISC_CKSEL_OFF       2'h0
`define ISC_CKSEL_15M36     2'h1
`define ISC_CKSEL_10M24     2'h2
`define ISC_MASK_RESET      8'hFF
`define ISC_FORCE_HIGH_US   50
`define ISC_CLK_MHZ         50
`define ISC_FORCE_CYCLES    (`ISC_FORCE_HIGH_US * `ISC_CLK_MHZ)
`define ISC_STRAP_TAKE      2'h2
`define ISC_STRAP_DONE      2'h3
`define ISC_PIN_HIGH        2'h3
`define ISC_PIN_LOW         2'h0
`endif

/* rtl/isc_pkg.sv */
// types shared by the interrupt, strap and clock-output block
// assumes the constants header is included where offsets are needed
package isc_pkg;
    typedef struct packed {
        logic       sync_low;
        logic       mode_high;
        logic       auto_low;
    } isc_straps_t;
    typedef struct packed {
        logic [1:0] sel;
        logic       auto_act;
    } isc_gcr0_t;
endpackage

/* bench/isc_chk.sv */
// port assertions for the interrupt, strap and clock-output block
// assumes it is bound to isc_top and sees only that module's ports
module isc_chk #(
    parameter int FORCE_CYC = 2500
) (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       irq_n_out,
    input wire logic       irq_n_oe,
    input wire logic       host_read_active,
    input wire logic       host_serial_out_oe,
    input wire logic       clock_out_oe,
    input wire logic       auto_activation_pin,
    input wire logic       activation_start
);
    logic [1:0] sel_q;
    int         fc;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // mirror of the clock select field and the forced-high countdown
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_q <= 2'h0;
            fc    <= 0;
        end else begin
            if (reg_wr && reg_addr == 4'h7) sel_q <= reg_wdata[2:1];
            if (reg_rd && reg_addr < 4'h3) fc <= FORCE_CYC;
            else if (fc != 0) fc <= fc - 1;
        end
    end
    force_high_a: assert property (fc != 0 && fc < FORCE_CYC |-> !irq_n_oe)
        else $error("interrupt pulled low inside forced interval");
    open_drain_a: assert property (irq_n_oe |-> irq_n_out == 1'b0)
        else $error("interrupt pin driven high");
    sdo_off_a: assert property (!host_read_active [*5] |-> !host_serial_out_oe)
        else $error("serial out driven with no read");
    sdo_on_a: assert property (host_read_active [*5] |-> host_serial_out_oe)
        else $error("serial out not driven during read");
    clk_off_a: assert property ((sel_q == 2'h0 || sel_q == 2'h3) [*6] |-> !clock_out_oe)
        else $error("clock out driven while off");
    clk_on_a: assert property ((sel_q == 2'h1 || sel_q == 2'h2) [*6] |-> clock_out_oe)
        else $error("clock out not driven when selected");
    act_strap_a: assert property (activation_start |-> !auto_activation_pin)
        else $error("activation started with strap high");
    act_pulse_a: assert property (activation_start |=> !activation_start)
        else $error("activation start longer than one cycle");
endmodule

bind isc_top isc_chk #(.FORCE_CYC(FORCE_CYC)) isc_chk_i (.ref_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .irq_n_out, .irq_n_oe, .host_read_active,
    .host_serial_out_oe, .clock_out_oe, .auto_activation_pin, .activation_start);

/* bench/isc_host_model.sv */
// host processor model: register port master and serial read-in-progress pin
// assumes strobes change just after a rising ref_clk edge and read data lag one cycle
module isc_host_model (
    input  wire logic       ref_clk,
    output logic [3:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            host_read_active,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_wdata, reg_wr, reg_rd, host_read_active} = '0;
    // one-cycle write strobe beside address and data
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read framed by the read-in-progress pin; data taken in the cycle after
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        host_read_active <= 1'b1;
        repeat (5) @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
        host_read_active <= 1'b0;
        #1;
    endtask
endmodule

/* bench/tb_top.sv */
// self-checking bench for the interrupt, strap and clock-output block
// assumes the host model owns the register port; pins and clocks are made here
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FC = 20;
    localparam int CW[3] = '{2, 4, 4};
    localparam int CL[3] = '{0, 1, 0};
    localparam int LO[3] = '{22, 9, 15};
    logic       ref_clk = 0, reset_n = 0, strap_mode = 1, host_serial_in = 0;
    logic       auto_activation_pin = 0, host_serial_out_d = 0, line_active = 0;
    logic       clk_15m36 = 0, clk_10m24_line = 0, clk_10m24_free = 0, ck_d;
    logic       reg_wr, reg_rd, host_read_active, irq_n_out, irq_n_oe, host_serial_out;
    logic       host_serial_out_oe, clock_out, clock_out_oe, activation_bit_select;
    logic       sync_8khz_function, auto_activation_ctl, activation_start;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_v, ev[3] = '{default: 8'h00};
    wire        mode_irq_pin_in = irq_n_oe ? irq_n_out : strap_mode;
    int         bad_count = 0, samples_checked = 0, cycles = 0, starts = 0, tog;
    isc_top #(.FORCE_CYC(FC)) isc_top_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_events(ev[0]), .st_events(ev[1]),
        .misc_events(ev[2]), .mode_irq_pin_in(mode_irq_pin_in), .irq_n_out(irq_n_out),
        .irq_n_oe(irq_n_oe), .host_serial_in(host_serial_in),
        .auto_activation_pin(auto_activation_pin), .host_read_active(host_read_active),
        .host_serial_out_d(host_serial_out_d), .host_serial_out(host_serial_out),
        .host_serial_out_oe(host_serial_out_oe), .line_active(line_active),
        .clk_15m36(clk_15m36), .clk_10m24_line(clk_10m24_line),
        .clk_10m24_free(clk_10m24_free), .clock_out(clock_out),
        .clock_out_oe(clock_out_oe), .activation_bit_select(activation_bit_select),
        .sync_8khz_function(sync_8khz_function), .auto_activation_ctl(auto_activation_ctl),
        .activation_start(activation_start));
    isc_host_model host_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .host_read_active(host_read_active),
        .reg_rdata(reg_rdata));
    initial forever #10 ref_clk = ~ref_clk;
    initial forever #33 clk_15m36 = ~clk_15m36;
    initial forever #80 clk_10m24_line = ~clk_10m24_line;
    initial forever #48 clk_10m24_free = ~clk_10m24_free;
    // cycle ceiling and activation pulse count
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (activation_start === 1'b1) starts <= starts + 1;
        if (cycles == 5000) begin
            bad_count++;
            results();
        end
    end
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(int i);
        @(posedge ref_clk);
        ev[i] <= 8'h01 << i;
        @(posedge ref_clk);
        ev[i] <= 8'h00;
        cyc(3);
    endtask
    // reset with given straps, then look at what was captured
    task automatic strap_test(logic m, logic s, logic a);
        int s0;
        s0 = starts;
        @(posedge ref_clk);
        strap_mode <= m;
        host_serial_in <= s;
        auto_activation_pin <= a;
        reset_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        cyc(12);
        chk("act_sel", activation_bit_select, m);
        chk("sync_fn", sync_8khz_function, !s);
        chk("auto_ctl", auto_activation_ctl, a);
        chk("starts", 8'(starts - s0), !a);
        chk("ck_oe", clock_out_oe, 0);
        host_i.rd(4'h8, rd_v);
        chk("gcr2", rd_v[6], m);
    endtask
    // masked set, unmask, read clear, forced interval, release
    task automatic irq_test(int i);
        logic [7:0] b;
        b = 8'h01 << i;
        pulse(i);
        chk("masked", irq_n_oe, 0);
        host_i.rd(4'h6, rd_v);
        chk("glob0", rd_v, 0);
        host_i.wr(4'(3 + i), 8'h00);
        cyc(3);
        chk("unmask", irq_n_oe, 1);
        host_i.rd(4'h6, rd_v);
        chk("glob1", rd_v, b);
        host_i.rd(4'(i), rd_v);
        chk("bits", rd_v, b);
        chk("forced", irq_n_oe, 0);
        pulse(i);
        chk("hold", irq_n_oe, 0);
        cyc(FC);
        chk("after", irq_n_oe, 1);
        host_i.rd(4'(i), rd_v);
        cyc(FC + 4);
        chk("idle", irq_n_oe, 0);
        host_i.rd(4'(i), rd_v);
        chk("clear", rd_v, 0);
        host_i.wr(4'(3 + i), 8'hFF);
    endtask
    // unmapped read, serial out idle, clock select and rate
    task automatic clk_test;
        host_i.rd(4'hF, rd_v);
        chk("unmapped", rd_v, 0);
        cyc(4);
        chk("sdo_oe", host_serial_out_oe, 0);
        @(posedge ref_clk);
        host_serial_out_d <= 1'b1;
        cyc(4);
        chk("sdo_d", host_serial_out, 1);
        for (int s = 0; s < 4; s++) begin
            host_i.wr(4'h7, 8'(s << 1));
            cyc(6);
            chk("ck_sel", clock_out_oe, s == 1 || s == 2);
        end
        for (int k = 0; k < 3; k++) begin
            host_i.wr(4'h7, 8'(CW[k]));
            @(posedge ref_clk);
            line_active <= CL[k][0];
            cyc(8);
            tog = 0;
            ck_d = clock_out;
            repeat (40) begin
                cyc(1);
                tog += int'(clock_out !== ck_d);
                ck_d = clock_out;
            end
            chk("ck_rate", tog >= LO[k] && tog <= LO[k] + 3, 1);
        end
    endtask
    initial begin
        strap_test(0, 1, 1);
        strap_test(1, 0, 0);
        for (int i = 0; i < 3; i++) irq_test(i);
        clk_test();
        results();
    end
endmodule
